// [test/battery_protect_priority_logic_tb.sv]
`timescale 1ns/1ps

module battery_protect_priority_logic_tb;
    import bppl_pkg::*;
    localparam int OCH = 100;
    localparam int ODI = 80;
    localparam int OCU = 60;
    localparam int EXC = 70;
    localparam int REL = 64;
    localparam int SHT = 3000;

    logic       ref_clk = 1'b0;
    logic       reset   = 1'b1;
    logic [4:0] cmd     = 5'h00;
    logic       tpin    = 1'b0;
    logic       och_in, odi_in, ocu_in, sht_in, exc_in, tst;
    logic       cg, dg, pu, pd, sb;
    logic [4:0] outs;
    int         n_fail      = 0;
    int         checks_done = 0;
    int         cyc         = 0;
    int         seed        = 32'hB193;
    int         len;

    assign outs = {cg, dg, pu, pd, sb};

    always #25 ref_clk = ~ref_clk;

    // ************************************************************
    // parts under test
    // ************************************************************
    bppl_pack_model i_model (.cmd(cmd), .tpin_high(tpin), .over_charge_in(och_in),
        .over_discharge_in(odi_in), .over_current_in(ocu_in), .short_in(sht_in),
        .excess_charger_in(exc_in), .test_shorten(tst));

    // short counts keep the run brief; every window below derives from them except the short one, which uses the fixed SHT delay
    bppl_core #(.OCH_DET_CYC(25'(OCH)), .OCH_REL_CYC(25'(REL)), .ODI_DET_CYC(25'(ODI)),
        .ODI_REL_CYC(25'(REL)), .OCU_DET_CYC(25'(OCU)), .OCU_REL_CYC(25'(REL)),
        .EXC_DET_CYC(25'(EXC)), .EXC_REL_CYC(25'(REL))) i_dut (
        .ref_clk(ref_clk), .reset(reset), .over_charge_in(och_in),
        .over_discharge_in(odi_in), .over_current_in(ocu_in), .short_in(sht_in),
        .excess_charger_in(exc_in), .test_shorten(tst), .charge_gate(cg),
        .discharge_gate(dg), .pull_up_en(pu), .pull_down_en(pd), .standby(sb));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_fail++;
            test_done();
        end
    end

    // compares all five outputs {cg, dg, pu, pd, sb} at once
    task automatic chk(input string what, input logic [4:0] seen, input logic [4:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic rst();
        cmd   = 5'h00;
        tpin  = 1'b0;
        reset = 1'b1;
        tick(12);
        reset = 1'b0;
    endtask

    // margin of a few cycles covers the two-stage synchroniser
    task automatic win(input string what, input int n, input logic [4:0] a, input logic [4:0] b);
        tick(n - 4);
        chk(what, outs, a);
        tick(10);
        chk(what, outs, b);
    endtask

    function automatic logic [4:0] trip_exp(input int l);
        return (l > OCH) ? 5'h08 : 5'h18;
    endfunction

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        rst();
        chk("reset", outs, 5'h18);
        cmd[IDX_OCH] = 1'b1;
        win("och", OCH, 5'h18, 5'h08);
        cmd[IDX_OCH] = 1'b0;
        win("och release", REL, 5'h08, 5'h18);
        cmd[IDX_OCH] = 1'b1;
        tick(60);
        cmd[IDX_OCH] = 1'b0;
        tick(2);
        cmd[IDX_OCH] = 1'b1;
        win("och restart", OCH, 5'h18, 5'h08);
        rst();
        tpin = 1'b1;
        cmd[IDX_OCH] = 1'b1;
        tick(8);
        chk("shortened", outs, 5'h08);
        cmd[IDX_SHT] = 1'b1;
        win("short", SHT, 5'h08, 5'h00);
        rst();
        cmd[IDX_OCU] = 1'b1;
        win("ocu", OCU, 5'h18, 5'h12);
        cmd[IDX_ODI] = 1'b1;
        win("ocu then odi", ODI, 5'h12, 5'h15);
        rst();
        cmd[IDX_ODI] = 1'b1;
        tick(30);
        cmd[IDX_OCU] = 1'b1;
        win("odi first", ODI - 30, 5'h18, 5'h15);
        tick(40);
        chk("ocu aborted", outs, 5'h15);
        cmd[IDX_ODI] = 1'b0;
        win("odi release", REL, 5'h15, 5'h18);
        rst();
        cmd[IDX_OCH] = 1'b1;
        cmd[IDX_ODI] = 1'b1;
        tick(ODI + 10);
        chk("odi held", outs, 5'h18);
        tick(OCH - ODI - 4);
        chk("och wins", outs, 5'h08);
        tick(ODI - 8);
        chk("odi resumed", outs, 5'h08);
        tick(14);
        chk("odi after och", outs, 5'h04);
        rst();
        cmd[IDX_OCH] = 1'b1;
        tick(50);
        cmd[IDX_OCU] = 1'b1;
        tick(OCH + 16);
        chk("ocu dropped", outs, 5'h08);
        rst();
        cmd[IDX_OCU] = 1'b1;
        tick(10);
        cmd[IDX_OCH] = 1'b1;
        win("och beside ocu", OCH, 5'h12, 5'h02);
        rst();
        cmd[IDX_OCU] = 1'b1;
        cmd[IDX_EXC] = 1'b1;
        tick(OCU + EXC + 30);
        chk("exc inhibited", outs, 5'h12);
        cmd[IDX_OCU] = 1'b0;
        for (int i = 0; i < 200 && dg !== 1'b1; i++) begin
            tick(1);
        end
        win("exc after gate", EXC, 5'h18, 5'h08);
        repeat (8) begin
            rst();
            len = 20 + int'($unsigned($random(seed)) % 160);
            if (len > OCH - 6 && len < OCH + 6) begin
                len = OCH + 10;
            end
            cmd[IDX_OCH] = 1'b1;
            tick(len);
            cmd[IDX_OCH] = 1'b0;
            tick(8);
            chk("och random", outs, trip_exp(len));
        end
        test_done();
    end
endmodule

// [test/bppl_pack_model.sv]
`timescale 1ns/1ps

// ************************************************************
// cell comparators, charger and load as seen by the guard
// ************************************************************
module bppl_pack_model
    import bppl_pkg::*;
(
    input  wire logic [4:0] cmd,
    input  wire logic       tpin_high,
    output logic            over_charge_in,
    output logic            over_discharge_in,
    output logic            over_current_in,
    output logic            short_in,
    output logic            excess_charger_in,
    output logic            test_shorten
);
    assign over_charge_in    = cmd[IDX_OCH];
    assign over_discharge_in = cmd[IDX_ODI];
    assign over_current_in   = cmd[IDX_OCU];
    assign short_in          = cmd[IDX_SHT];
    assign excess_charger_in = cmd[IDX_EXC];
    // strapped to the negative rail unless shortened mode is wanted
    assign test_shorten      = tpin_high;
endmodule

// [verilog/bppl_core.sv]
`timescale 1ns/1ps


module bppl_core
    import bppl_pkg::*;
#(
    parameter logic [CNT_W-1:0] OCH_DET_CYC = CNT_W'(OCH_DET_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] OCH_REL_CYC = CNT_W'(OCH_REL_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] ODI_DET_CYC = CNT_W'(ODI_DET_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] ODI_REL_CYC = CNT_W'(ODI_REL_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] OCU_DET_CYC = CNT_W'(OCU_DET_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] OCU_REL_CYC = CNT_W'(OCU_REL_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] EXC_DET_CYC = CNT_W'(EXC_DET_US * CLK_MHZ),
    parameter logic [CNT_W-1:0] EXC_REL_CYC = CNT_W'(EXC_REL_US * CLK_MHZ)
)
(
    input  wire logic ref_clk,
    input  wire logic reset,
    input  wire logic over_charge_in,
    input  wire logic over_discharge_in,
    input  wire logic over_current_in,
    input  wire logic short_in,
    input  wire logic excess_charger_in,
    input  wire logic test_shorten,
    output logic      charge_gate,
    output logic      discharge_gate,
    output logic      pull_up_en,
    output logic      pull_down_en,
    output logic      standby
);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [IN_N-1:0] sync_meta;
    logic [IN_N-1:0] sync_in;
    logic [IN_N-1:0] raw_in;

    always_comb begin
        raw_in            = '0;
        raw_in[IN_OCH]    = over_charge_in;
        raw_in[IN_ODI]    = over_discharge_in;
        raw_in[IN_OCU]    = over_current_in;
        raw_in[IN_SHT]    = short_in;
        raw_in[IN_EXC]    = excess_charger_in;
        // an open pin is expected to read low, so normal delays apply
        raw_in[IN_SHORTN] = test_shorten;
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sync_meta <= '0;
            sync_in   <= '0;
        end else begin
            sync_meta <= raw_in;
            sync_in   <= sync_meta;
        end
    end

    logic och_c;
    logic odi_c;
    logic ocu_c;
    logic sht_c;
    logic exc_c;
    logic shorten;

    assign och_c   = sync_in[IN_OCH];
    assign odi_c   = sync_in[IN_ODI];
    assign ocu_c   = sync_in[IN_OCU];
    assign sht_c   = sync_in[IN_SHT];
    assign exc_c   = sync_in[IN_EXC];
    assign shorten = sync_in[IN_SHORTN];

    // ************************************************************
    // delay selection
    // ************************************************************
    logic [DET_N-1:0] est;
    logic [DET_N-1:0] next_est;
    logic [DET_N-1:0] run;
    logic [DET_N-1:0] expired;
    logic [CNT_W-1:0] limit [DET_N];
    logic             och_pending;

    function automatic logic [CNT_W-1:0] scale(input logic [CNT_W-1:0] full,
                                               input logic             cut);
        logic [CNT_W-1:0] short_val;
        short_val = full >> SHORTEN_SHIFT;
        if (!cut) begin
            return full;
        end
        // never let a cut delay collapse to nothing
        return (short_val == CNT_ZERO) ? CNT_ONE : short_val;
    endfunction

    always_comb begin
        // counter delays follow the test pin, cut or full
        limit[IDX_OCH] = scale(est[IDX_OCH] ? OCH_REL_CYC : OCH_DET_CYC, shorten);
        limit[IDX_ODI] = scale(est[IDX_ODI] ? ODI_REL_CYC : ODI_DET_CYC, shorten);
        limit[IDX_OCU] = scale(est[IDX_OCU] ? OCU_REL_CYC : OCU_DET_CYC, shorten);
        limit[IDX_EXC] = scale(est[IDX_EXC] ? EXC_REL_CYC : EXC_DET_CYC, shorten);
        // short detect is fixed; its release shares the over-current timing
        limit[IDX_SHT] = est[IDX_SHT] ? scale(OCU_REL_CYC, shorten) : SHT_DET_CYC;
    end

    // ************************************************************
    // run conditions and arbitration
    // ************************************************************
    always_comb begin
        och_pending = och_c && !est[IDX_OCH];
        run = '0;
        // over-charge always times, beside over-current too
        run[IDX_OCH] = est[IDX_OCH] ? !och_c : och_c;
        if (est[IDX_ODI]) begin
            run[IDX_ODI] = !odi_c;
        end else begin
            // held off while over-charge is pending, resumes afterwards
            run[IDX_ODI] = odi_c && !och_pending;
        end
        if (est[IDX_OCU]) begin
            run[IDX_OCU] = !ocu_c;
        end else begin
            // aborted once over-charge or over-discharge is established
            run[IDX_OCU] = ocu_c && !est[IDX_OCH] && !est[IDX_ODI];
        end
        // no other state gates the short path
        run[IDX_SHT] = est[IDX_SHT] ? (!sht_c && !ocu_c) : sht_c;
        if (est[IDX_EXC]) begin
            run[IDX_EXC] = !exc_c;
        end else begin
            run[IDX_EXC] = exc_c && !est[IDX_ODI] && !est[IDX_OCU] && !est[IDX_SHT]
                           && discharge_gate;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < DET_N; gi++) begin : g_timer
            bppl_delay u_delay (
                .ref_clk (ref_clk),
                .reset   (reset),
                .run     (run[gi]),
                .limit   (limit[gi]),
                .expired (expired[gi])
            );
        end
    endgenerate

    // ************************************************************
    // detection states and outputs
    // ************************************************************
    logic next_charge_gate;
    logic next_discharge_gate;
    logic next_pull_up_en;
    logic next_pull_down_en;
    logic next_standby;

    always_comb begin
        // each expiry enters or leaves the state it timed
        next_est            = est ^ expired;
        next_charge_gate    = !(next_est[IDX_OCH] || next_est[IDX_EXC]);
        next_discharge_gate = !(next_est[IDX_ODI] || next_est[IDX_OCU]
                                || next_est[IDX_SHT]);
        // over-discharge always pulls up, replacing any pull-down
        next_pull_up_en     = next_est[IDX_ODI];
        // pull-down only when the current fault came first; an over-charge latched
        // before it leaves the node released, one latched after it keeps the pull
        next_pull_down_en   = (next_est[IDX_OCU] || next_est[IDX_SHT])
                              && !next_est[IDX_ODI]
                              && (!next_est[IDX_OCH] || pull_down_en);
        // over-charge present keeps the part awake
        next_standby        = next_est[IDX_ODI] && !next_est[IDX_OCH];
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            // come up with both transistors on and nothing latched
            est            <= '0;
            charge_gate    <= 1'b1;
            discharge_gate <= 1'b1;
            pull_up_en     <= 1'b0;
            pull_down_en   <= 1'b0;
            standby        <= 1'b0;
        end else begin
            est            <= next_est;
            charge_gate    <= next_charge_gate;
            discharge_gate <= next_discharge_gate;
            pull_up_en     <= next_pull_up_en;
            pull_down_en   <= next_pull_down_en;
            standby        <= next_standby;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    charge_gate_off_a: assert property (est[IDX_OCH] |-> !charge_gate)
        else $error("charge gate high during over-charge");

    discharge_gate_off_a: assert property ($rose(est[IDX_SHT]) |-> !discharge_gate)
        else $error("discharge gate high after short");

    pull_exclusive_a: assert property (!(pull_up_en && pull_down_en))
        else $error("both pulls on");

    och_no_standby_a: assert property (est[IDX_OCH] && est[IDX_ODI]
                                       |-> !standby && pull_up_en)
        else $error("standby with over-charge");

    ocu_abort_och_a: assert property (!est[IDX_OCU] && est[IDX_OCH] |-> !run[IDX_OCU])
        else $error("over-current timing during over-charge");

    ocu_abort_odi_a: assert property (!est[IDX_OCU] && est[IDX_ODI] |-> !run[IDX_OCU])
        else $error("over-current timing during over-discharge");

    odi_hold_a: assert property (och_pending && !est[IDX_ODI] |-> !run[IDX_ODI])
        else $error("over-discharge timed during pending over-charge");

    exc_inhibit_a: assert property (!est[IDX_EXC] && run[IDX_EXC]
                                    |-> discharge_gate && !est[IDX_OCU])
        else $error("excess charger timed while inhibited");

    short_fixed_a: assert property (!est[IDX_SHT] |-> limit[IDX_SHT] == SHT_DET_CYC)
        else $error("short delay altered");

    shorten_cut_a: assert property (shorten && !est[IDX_OCH]
                                    |-> limit[IDX_OCH] < OCH_DET_CYC)
        else $error("test pin did not cut delay");

    normal_full_a: assert property (!shorten && !est[IDX_OCH]
                                    |-> limit[IDX_OCH] == OCH_DET_CYC)
        else $error("normal delay altered");

    pulldown_first_a: assert property (est[IDX_OCU] && !est[IDX_ODI] && !est[IDX_OCH]
                                       |-> pull_down_en)
        else $error("no pull-down after over-current");

    pull_keep_a: assert property ($rose(est[IDX_OCH]) && $past(pull_down_en)
                                  && !est[IDX_ODI] && (est[IDX_OCU] || est[IDX_SHT])
                                  |-> pull_down_en)
        else $error("pull-down dropped when over-charge followed");

    och_first_release_a: assert property ($rose(est[IDX_OCH]) && !$past(pull_down_en)
                                          |-> !pull_down_en)
        else $error("pull-down after over-charge came first");

    reset_state_a: assert property ($fell(reset) |-> charge_gate && discharge_gate
                                    && !pull_up_en && !pull_down_en && !standby && est == '0)
        else $error("outputs not idle after reset");

    pull_up_odi_a: assert property (est[IDX_ODI] |-> pull_up_en)
        else $error("no pull-up during over-discharge");

    standby_odi_a: assert property (est[IDX_ODI] && !est[IDX_OCH] |-> standby)
        else $error("no standby after over-discharge");

    ocu_swap_a: assert property (est[IDX_OCU] && est[IDX_ODI] && !est[IDX_OCH]
                                 |-> pull_up_en && !pull_down_en && standby)
        else $error("pull not swapped after over-discharge");

    exc_gate_a: assert property (!est[IDX_EXC] && !discharge_gate |-> !run[IDX_EXC])
        else $error("excess charger timed with discharge gate low");

    short_free_a: assert property (sht_c && !est[IDX_SHT] |-> run[IDX_SHT])
        else $error("short detection blocked");

    och_runs_a: assert property (och_c && !est[IDX_OCH] && est[IDX_OCU]
                                 |-> run[IDX_OCH])
        else $error("over-charge timing blocked by over-current");

    odi_resume_a: assert property (odi_c && !est[IDX_ODI] && est[IDX_OCH]
                                   |-> run[IDX_ODI])
        else $error("over-discharge not resumed after over-charge");

    odi_beside_ocu_a: assert property (odi_c && !est[IDX_ODI] && est[IDX_OCU]
                                       && !och_pending |-> run[IDX_ODI])
        else $error("over-discharge timing blocked by over-current");

    dis_gate_off_a: assert property (est[IDX_OCU] || est[IDX_ODI] |-> !discharge_gate)
        else $error("discharge gate high during discharge fault");

    exc_charge_off_a: assert property (est[IDX_EXC] |-> !charge_gate)
        else $error("charge gate high during excess charger");

endmodule

// [verilog/bppl_delay.sv]
`timescale 1ns/1ps

module bppl_delay
    import bppl_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] limit,
    output logic                  expired
);

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] next_cnt;

    // ************************************************************
    // counter
    // ************************************************************
    always_comb begin
        expired  = run && (cnt >= limit - CNT_ONE);
        next_cnt = cnt + CNT_ONE;
        if (!run || expired) begin
            // a vanished condition restarts the delay from zero
            next_cnt = CNT_ZERO;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cnt <= CNT_ZERO;
        end else begin
            cnt <= next_cnt;
        end
    end

endmodule

// [verilog/bppl_pkg.sv]
package bppl_pkg;

    // ************************************************************
    // detection index
    // ************************************************************
    localparam int DET_N   = 5;
    localparam int IDX_OCH = 0;
    localparam int IDX_ODI = 1;
    localparam int IDX_OCU = 2;
    localparam int IDX_SHT = 3;
    localparam int IDX_EXC = 4;

    // ************************************************************
    // synchronised input positions
    // ************************************************************
    localparam int IN_N      = 6;
    localparam int IN_OCH    = 0;
    localparam int IN_ODI    = 1;
    localparam int IN_OCU    = 2;
    localparam int IN_SHT    = 3;
    localparam int IN_EXC    = 4;
    localparam int IN_SHORTN = 5;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CNT_W   = 25;
    localparam int CLK_MHZ = 20;

    localparam int OCH_DET_US = 1000000;
    localparam int OCH_REL_US = 16000;
    localparam int ODI_DET_US = 125000;
    localparam int ODI_REL_US = 16000;
    localparam int OCU_DET_US = 10000;
    localparam int OCU_REL_US = 16000;
    localparam int EXC_DET_US = 16000;
    localparam int EXC_REL_US = 16000;
    localparam int SHT_DET_US = 150;

    localparam logic [CNT_W-1:0] SHT_DET_CYC = CNT_W'(SHT_DET_US * CLK_MHZ);

    // test mode divides counter delays by two to this power
    localparam int SHORTEN_SHIFT = 6;

    localparam logic [CNT_W-1:0] CNT_ONE  = 25'h0000001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;

endpackage
